// >>> gled_pkg.sv
// Shared types, constants and reset values for the GPIO / LED indicator port
package gled_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int unsigned PIN_CNT = 3;
   localparam int unsigned CNT_W   = 23;

   // ------------------------------------------------------------------
   // Lamp positions inside the indicator_pins vector
   // ------------------------------------------------------------------
   localparam int unsigned SPEED_POS  = 0;
   localparam int unsigned LINK_POS   = 1;
   localparam int unsigned DUPLEX_POS = 2;

   // ------------------------------------------------------------------
   // Activity lamp timing
   // ------------------------------------------------------------------
   localparam int unsigned LAMP_PULSE_MS  = 80;
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned NS_PER_MS      = 1_000_000;
   localparam int unsigned PULSE_CYC_DEF  =
      (LAMP_PULSE_MS * NS_PER_MS) / CLK_PERIOD_NS;

   typedef logic [CNT_W-1:0]   gled_cnt_t;
   typedef logic [PIN_CNT-1:0] gled_vec_t;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   // Per-pin configuration
   typedef struct packed {
      logic led_sel;   // 1: pin is an indicator lamp
      logic dir_out;   // 1: general-purpose output
      logic open_drn;  // 1: open-drain output type
      logic dout;      // Output data
   } gled_pin_cfg_s;

   // Link state from the PHY side, same clock
   typedef struct packed {
      logic link_up;
      logic speed_10;
      logic autoneg_busy;
      logic full_duplex;
      logic activity;
   } gled_link_s;

   typedef enum logic [1:0] {
      ACT_IDLE,
      ACT_OFF,
      ACT_HOLD
   } gled_act_e;

   // Activity timer state
   typedef struct packed {
      gled_act_e state;
      gled_cnt_t cnt;
      logic      pending;
      logic      lamp_n;
   } gled_act_s;

   // Top-level state
   typedef struct packed {
      gled_vec_t sync1;
      gled_vec_t sync2;
      gled_vec_t pin_out;
      gled_vec_t pin_oe;
   } gled_top_s;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam gled_act_s ACT_RST = '{
      state:   ACT_IDLE,
      cnt:     '0,
      pending: 1'b0,
      lamp_n:  1'b1
   };

   localparam gled_top_s TOP_RST = '{
      sync1:   '0,
      sync2:   '0,
      pin_out: '0,
      pin_oe:  '0
   };

endpackage

// >>> gled_act_timer.sv
// Link and activity lamp timer: 80 ms off pulse, 80 ms minimum on
`timescale 1ns/100ps
module gled_act_timer #(
   parameter gled_pkg::gled_cnt_t PULSE_CYCLES =
      gled_pkg::gled_cnt_t'(gled_pkg::PULSE_CYC_DEF)
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic link_up,
   input  wire logic activity,
   output logic      lamp_n
);
   import gled_pkg::*;

   localparam gled_cnt_t LAST = gled_cnt_t'(PULSE_CYCLES - 1'b1);

   gled_act_s st_r;
   gled_act_s st_nxt;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.cnt = gled_cnt_t'(st_r.cnt + 1'b1);
      // Activity seen during the on hold is remembered; a clear in the case below beats the set
      if (activity) begin
         st_nxt.pending = 1'b1;
      end
      unique case (st_r.state)
         ACT_IDLE: begin
            st_nxt.cnt     = '0;
            st_nxt.pending = 1'b0;
            if (link_up && activity) begin
               st_nxt.state = ACT_OFF;
            end
         end
         ACT_OFF: begin
            if (st_r.cnt == LAST) begin
               st_nxt.state   = ACT_HOLD;
               st_nxt.cnt     = '0;
               st_nxt.pending = activity;
            end
         end
         ACT_HOLD: begin
            if (st_r.cnt == LAST) begin
               st_nxt.cnt     = '0;
               st_nxt.pending = 1'b0;
               st_nxt.state   = (st_r.pending || activity) ?
                                ACT_OFF : ACT_IDLE;
            end
         end
         default: begin
            st_nxt.state = ACT_IDLE;                           // Unused code
         end
      endcase
      // Losing the link abandons any pulse in progress
      if (!link_up) begin
         st_nxt.state   = ACT_IDLE;
         st_nxt.cnt     = '0;
         st_nxt.pending = 1'b0;
      end
      // Lit with a link, dark during the off pulse
      st_nxt.lamp_n = !link_up || (st_nxt.state == ACT_OFF);
   end

   // State register, cleared by reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r <= ACT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lamp_n = st_r.lamp_n;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   AST_OFF_START: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st_r.state == ACT_IDLE && link_up && activity) |=>
         (lamp_n && st_r.state == ACT_OFF && st_r.cnt == '0))
      else $error("Activity did not start an off pulse");

   AST_OFF_LENGTH: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st_r.state == ACT_OFF && st_r.cnt != LAST && link_up) |=>
         (st_r.state == ACT_OFF && lamp_n &&
          st_r.cnt == gled_cnt_t'($past(st_r.cnt) + 1'b1)))
      else $error("Off pulse ended early");

   AST_HOLD_ENTRY: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st_r.state == ACT_OFF && st_r.cnt == LAST && link_up) |=>
         (st_r.state == ACT_HOLD && !lamp_n && st_r.cnt == '0))
      else $error("Off pulse not followed by on hold");

   AST_HOLD_MIN: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st_r.state == ACT_HOLD && st_r.cnt != LAST && link_up) |=>
         (!lamp_n && st_r.state == ACT_HOLD))
      else $error("On hold shorter than the minimum");

   AST_REPEAT: assert property (
      @(posedge sys_clk) disable iff (srst)
      (st_r.state == ACT_HOLD && st_r.cnt == LAST && link_up &&
       (st_r.pending || activity)) |=> (lamp_n && st_r.state == ACT_OFF))
      else $error("Pending activity did not repeat the pulse");

   AST_CNT_RESET: assert property (
      @(posedge sys_clk)
      srst |=> (st_r.cnt == '0 && st_r.state == ACT_IDLE && lamp_n))
      else $error("Reset did not clear the lamp timer");

   COV_PULSE: cover property (
      @(posedge sys_clk) disable iff (srst)
      st_r.state == ACT_OFF ##1 st_r.state == ACT_HOLD);

   COV_REPEAT: cover property (
      @(posedge sys_clk) disable iff (srst)
      st_r.state == ACT_HOLD ##1 st_r.state == ACT_OFF);

endmodule // gled_act_timer

// >>> gled_indicator_port.sv
// Three-pin GPIO port with open-drain status lamp functions
`timescale 1ns/100ps

// Overview of operation
// - Each of the three pins works on its own as push-pull output, open-drain output or input.
// - Per-pin configuration inputs pick each pin's direction and output type.
// - Each pin can be switched over from its general-purpose function to a lamp.
// - A lamp pin only pulls low or releases, it never drives high.
// - The speed lamp is pulled low at 100 Mb/s, during auto-negotiation and with no cable.
// - The speed lamp is released high only while the link runs at 10 Mb/s.
// - The link and activity lamp is pulled low while a valid link is present, except during an off pulse.
// - Traffic in either direction turns the link and activity lamp off for 80 ms.
// - After each off pulse the lamp stays lit at least 80 ms before another pulse may start.
// - The duplex lamp is pulled low while the link runs full duplex.
module gled_indicator_port #(
   parameter gled_pkg::gled_cnt_t PULSE_CYCLES =
      gled_pkg::gled_cnt_t'(gled_pkg::PULSE_CYC_DEF)
) (
   input  wire logic                    sys_clk,
   input  wire logic                    srst,
   input  gled_pkg::gled_pin_cfg_s [2:0] pin_cfg,
   input  gled_pkg::gled_link_s         link_stat,
   input  wire gled_pkg::gled_vec_t     indicator_pins_in,
   output gled_pkg::gled_vec_t          indicator_pins_out,
   output gled_pkg::gled_vec_t          indicator_pins_oe,
   output gled_pkg::gled_vec_t          gpio_din
);
   import gled_pkg::*;

   gled_top_s st_r;
   gled_top_s st_nxt;
   logic      link_act_lamp_n;
   gled_vec_t lamp_n;
   logic      speed_lamp_n;
   logic      full_duplex_lamp_n;

   // ------------------------------------------------------------------
   // Usage notes
   // ------------------------------------------------------------------
   // Lamp positions: pin 0 speed, pin 1 link and activity, pin 2
   // duplex; a pin shows its lamp only while its lamp select is set.
   // Configuration and link state come from logic on sys_clk and are
   // used as they stand; only the pad levels cross into this domain.
   // Pad levels reach gpio_din two clocks late, so a pulse shorter
   // than a clock on a pad may be missed altogether.
   // Every pad output and enable leaves a flop: a mode change shows
   // one clock later, and the link lamp one more through its timer.
   // Lamps sit between the pull-up and the pad, so pulling low
   // lights them and releasing darkens them; nothing drives high.
   // Without a link the link and duplex lamps are dark and the speed
   // lamp is lit, so an unplugged board shows a single lamp.
   // The output data of a lamp pin is ignored until the pin returns
   // to its general-purpose function.
   // Activity may be a level or a pulse; during the lit hold it is
   // remembered and starts the next off pulse when the hold ends.
   // Losing the link abandons a pulse at once and clears the timer.

   // ------------------------------------------------------------------
   // Activity lamp timer
   // ------------------------------------------------------------------
   // The timer's own flop makes the link lamp lag the others a clock
   gled_act_timer #(
      .PULSE_CYCLES (PULSE_CYCLES)
   ) u_act_timer (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .link_up  (link_stat.link_up),
      .activity (link_stat.activity),
      .lamp_n   (link_act_lamp_n)
   );

   // ------------------------------------------------------------------
   // Lamp levels
   // ------------------------------------------------------------------
   // Dark (high) only at 10 Mb/s on a settled link
   assign speed_lamp_n = link_stat.link_up && link_stat.speed_10 &&
                         !link_stat.autoneg_busy;
   // Duplex lamp lit only on a full-duplex link
   assign full_duplex_lamp_n = !(link_stat.link_up &&
                                 link_stat.full_duplex);
   // Gather the lamps by pin position
   assign lamp_n[SPEED_POS]  = speed_lamp_n;
   assign lamp_n[LINK_POS]   = link_act_lamp_n;
   assign lamp_n[DUPLEX_POS] = full_duplex_lamp_n;

   // ------------------------------------------------------------------
   // Pin drivers and input synchroniser
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Two stages before anything looks at the pin level
      st_nxt.sync1 = indicator_pins_in;
      st_nxt.sync2 = st_r.sync1;
      // Lamp select wins over the general-purpose mode
      for (int i = 0; i < PIN_CNT; i++) begin
         if (pin_cfg[i].led_sel) begin
            // Lamp: pull low to light, release to darken
            st_nxt.pin_out[i] = 1'b0;
            st_nxt.pin_oe[i]  = !lamp_n[i];
         end else if (!pin_cfg[i].dir_out) begin
            // Input: released, level read through the synchroniser
            st_nxt.pin_out[i] = 1'b0;
            st_nxt.pin_oe[i]  = 1'b0;
         end else if (pin_cfg[i].open_drn) begin
            // Open-drain: pull low for a zero, release for a one
            st_nxt.pin_out[i] = 1'b0;
            st_nxt.pin_oe[i]  = !pin_cfg[i].dout;
         end else begin
            // Push-pull: drive the data both ways
            st_nxt.pin_out[i] = pin_cfg[i].dout;
            st_nxt.pin_oe[i]  = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r <= TOP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pad drive and sampled levels straight from the state flops
   assign indicator_pins_out = st_r.pin_out;
   assign indicator_pins_oe  = st_r.pin_oe;
   assign gpio_din           = st_r.sync2;

   // ------------------------------------------------------------------
   // Per-pin mode checks
   // ------------------------------------------------------------------
   for (genvar g = 0; g < PIN_CNT; g++) begin : g_chk
      // Push-pull pin drives its data both ways
      AST_PUSH_PULL: assert property (
         @(posedge sys_clk) disable iff (srst)
         (!pin_cfg[g].led_sel && pin_cfg[g].dir_out &&
          !pin_cfg[g].open_drn) |=>
            (indicator_pins_oe[g] &&
             indicator_pins_out[g] == $past(pin_cfg[g].dout)))
         else $error("Push-pull pin not driving its data");


      // Open-drain pin only pulls low, for a zero
      AST_OPEN_DRAIN: assert property (
         @(posedge sys_clk) disable iff (srst)
         (!pin_cfg[g].led_sel && pin_cfg[g].dir_out &&
          pin_cfg[g].open_drn) |=>
            (!indicator_pins_out[g] &&
             indicator_pins_oe[g] == !$past(pin_cfg[g].dout)))
         else $error("Open-drain pin driving wrongly");


      // Input pin is never driven
      AST_INPUT_RELEASE: assert property (
         @(posedge sys_clk) disable iff (srst)
         (!pin_cfg[g].led_sel && !pin_cfg[g].dir_out) |=>
            !indicator_pins_oe[g])
         else $error("Input pin is being driven");


      // Lamp pin never drives high
      AST_LAMP_NO_HIGH: assert property (
         @(posedge sys_clk) disable iff (srst)
         pin_cfg[g].led_sel |=>
            !(indicator_pins_oe[g] && indicator_pins_out[g]))
         else $error("Lamp pin driven high");


      // Lamp pin enable follows the lamp a clock later
      AST_LAMP_FOLLOWS: assert property (
         @(posedge sys_clk) disable iff (srst)
         pin_cfg[g].led_sel |=> (indicator_pins_oe[g] == !$past(lamp_n[g])))
         else $error("Lamp pin not following its lamp");

      // A lit lamp pulls its pin low
      AST_LAMP_LIT: assert property (
         @(posedge sys_clk) disable iff (srst)
         (pin_cfg[g].led_sel && !lamp_n[g]) |=>
            (indicator_pins_oe[g] && !indicator_pins_out[g]))
         else $error("Lit lamp not pulling its pin low");

      // Input pin leaves its output value at zero
      AST_INPUT_OUT_ZERO: assert property (
         @(posedge sys_clk) disable iff (srst)
         (!pin_cfg[g].led_sel && !pin_cfg[g].dir_out) |=>
            !indicator_pins_out[g])
         else $error("Input pin output value not zero");

      // Lamp pin output value is always zero
      AST_LAMP_OUT_ZERO: assert property (
         @(posedge sys_clk) disable iff (srst)
         pin_cfg[g].led_sel |=> !indicator_pins_out[g])
         else $error("Lamp pin output value not zero");
   end

   // ------------------------------------------------------------------
   // Lamp function checks
   // ------------------------------------------------------------------
   // Speed lamp lit unless the link runs settled at 10 Mb/s
   AST_SPEED_LOW: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[SPEED_POS].led_sel &&
       (!link_stat.link_up || !link_stat.speed_10 ||
        link_stat.autoneg_busy)) |=>
         (indicator_pins_oe[SPEED_POS] && !indicator_pins_out[SPEED_POS]))
      else $error("Speed lamp not pulled low");

   // Speed lamp released on a settled 10 Mb/s link
   AST_SPEED_HIGH: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[SPEED_POS].led_sel && link_stat.link_up &&
       link_stat.speed_10 && !link_stat.autoneg_busy) |=>
         !indicator_pins_oe[SPEED_POS])
      else $error("Speed lamp not released at 10 Mb/s");

   // Link lamp lit while the timer holds it lit
   AST_LINK_LIT: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[LINK_POS].led_sel && link_stat.link_up &&
       !link_stat.activity && !link_act_lamp_n) |=>
         indicator_pins_oe[LINK_POS])
      else $error("Link lamp dark with a valid link");

   // Timer off pulse reaches the pin a clock later
   AST_ACT_PULSE: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[LINK_POS].led_sel && $rose(link_act_lamp_n) &&
       link_stat.link_up) |=> !indicator_pins_oe[LINK_POS])
      else $error("Activity pulse not seen at the pin");

   // Duplex lamp lit on a full-duplex link
   AST_DUPLEX: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[DUPLEX_POS].led_sel && link_stat.link_up &&
       link_stat.full_duplex) |=>
         (indicator_pins_oe[DUPLEX_POS] &&
          !indicator_pins_out[DUPLEX_POS]))
      else $error("Duplex lamp not lit in full duplex");

   // Speed lamp lit while auto-negotiation runs, whatever the speed
   AST_SPEED_NEG: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[SPEED_POS].led_sel && link_stat.autoneg_busy) |=>
         (indicator_pins_oe[SPEED_POS] && !indicator_pins_out[SPEED_POS]))
      else $error("Speed lamp dark during auto-negotiation");

   // Speed lamp lit with no cable or link
   AST_SPEED_NOLINK: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[SPEED_POS].led_sel && !link_stat.link_up) |=>
         (indicator_pins_oe[SPEED_POS] && !indicator_pins_out[SPEED_POS]))
      else $error("Speed lamp dark with no link");

   // Speed lamp lit on a 100 Mb/s link
   AST_SPEED_100: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[SPEED_POS].led_sel && link_stat.link_up &&
       !link_stat.speed_10) |=>
         (indicator_pins_oe[SPEED_POS] && !indicator_pins_out[SPEED_POS]))
      else $error("Speed lamp dark at 100 Mb/s");

   // Link lamp dark two clocks after the link is gone
   AST_LINK_DARK: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[LINK_POS].led_sel && !link_stat.link_up) ##1
         pin_cfg[LINK_POS].led_sel |=> !indicator_pins_oe[LINK_POS])
      else $error("Link lamp lit with no link");

   // Duplex lamp dark unless the link runs full duplex
   AST_DUPLEX_DARK: assert property (
      @(posedge sys_clk) disable iff (srst)
      (pin_cfg[DUPLEX_POS].led_sel &&
       !(link_stat.link_up && link_stat.full_duplex)) |=>
         !indicator_pins_oe[DUPLEX_POS])
      else $error("Duplex lamp lit without full duplex");

   // ------------------------------------------------------------------
   // Reset and input checks
   // ------------------------------------------------------------------
   // Reset releases every pin and clears the sampled levels
   AST_RESET_QUIET: assert property (
      @(posedge sys_clk)
      srst |=> (indicator_pins_oe == '0 && indicator_pins_out == '0 &&
                gpio_din == '0))
      else $error("Pins not released by reset");

   // Pad level shows at gpio_din two clocks after it is sampled
   AST_DIN_SYNC: assert property (
      @(posedge sys_clk) disable iff (srst)
      1'b1 |-> ##2 (gpio_din == $past(indicator_pins_in, 2)))
      else $error("Input level not passed through the synchroniser");

   // ------------------------------------------------------------------
   // Coverage of the main scenarios
   // ------------------------------------------------------------------
   // Link lamp flashes for activity
   COV_LINK_FLASH: cover property (
      @(posedge sys_clk) disable iff (srst)
      pin_cfg[LINK_POS].led_sel && !link_act_lamp_n ##1 link_act_lamp_n);

   // Speed lamp released at 10 Mb/s
   COV_SPEED_10: cover property (
      @(posedge sys_clk) disable iff (srst)
      pin_cfg[SPEED_POS].led_sel && !indicator_pins_oe[SPEED_POS] &&
      link_stat.link_up);

   // Pin 0 used as an open-drain output
   COV_OPEN_DRAIN: cover property (
      @(posedge sys_clk) disable iff (srst)
      !pin_cfg[0].led_sel && pin_cfg[0].dir_out && pin_cfg[0].open_drn);

endmodule // gled_indicator_port

// >>> gled_board.sv
// Board model: pull-ups, external drivers and lamps on the indicator pins
`timescale 1ns/100ps
module gled_board (
   input  gled_pkg::gled_vec_t pins_out,
   input  gled_pkg::gled_vec_t pins_oe,
   input  gled_pkg::gled_vec_t ext_en,
   input  gled_pkg::gled_vec_t ext_val,
   output gled_pkg::gled_vec_t pin_lvl,
   output gled_pkg::gled_vec_t lamp_lit
);
   import gled_pkg::*;

   // ------------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------------
   // Released pins with no external driver float up through the board pull-up
   always_comb begin
      for (int i = 0; i < PIN_CNT; i++) begin
         if (pins_oe[i]) begin
            pin_lvl[i] = pins_out[i];
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i];
         end else begin
            pin_lvl[i] = 1'b1;
         end
      end
   end

   // Lamp from pull-up to pin: lit while the pin sits low
   assign lamp_lit = ~pin_lvl;
endmodule // gled_board

// >>> gled_indicator_port_bench.sv
// Self-checking bench for the GPIO and status lamp port
`timescale 1ns/100ps
module gled_indicator_port_bench;
   import gled_pkg::*;

   localparam int PULSE = 8;

   logic                    sys_clk;
   logic                    srst;
   gled_pin_cfg_s [2:0]     cfg;
   gled_link_s              link;
   gled_vec_t               pin_lvl;
   gled_vec_t               out;
   gled_vec_t               oe;
   gled_vec_t               din;
   gled_vec_t               ext_en;
   gled_vec_t               ext_val;
   int                      fails;
   int                      tests_run;

   // ------------------------------------------------------------------
   // Design and board
   // ------------------------------------------------------------------
   gled_indicator_port #(.PULSE_CYCLES(gled_cnt_t'(PULSE)))
      u_gled_indicator_port (.sys_clk(sys_clk), .srst(srst),
      .pin_cfg(cfg), .link_stat(link), .indicator_pins_in(pin_lvl),
      .indicator_pins_out(out), .indicator_pins_oe(oe), .gpio_din(din));

   gled_board u_gled_board (.pins_out(out), .pins_oe(oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl),
      .lamp_lit());

   // Clock at 100 MHz
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input gled_vec_t got, input gled_vec_t exp,
                      input string msg);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t: %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp, input string msg);
      tests_run++;
      if (got != exp) begin
         fails++;
         $display("BAD %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Cycles the link lamp enable keeps the value v, capped at lim
   task automatic run(input logic v, input int lim, output int n);
      n = 0;
      while (oe[1] === v && n < lim) begin
         tick(1);
         n++;
      end
   endtask

   // Bounded wait for the link lamp enable to reach v
   task automatic wait_for(input logic v);
      int n;
      n = 0;
      while (oe[1] !== v && n < 20) begin
         tick(1);
         n++;
      end
      if (oe[1] !== v) begin
         fails++;
         $display("BAD %0t: link lamp wait timed out", $time);
         finish_test();
      end
   endtask

   // All pins as lamps, data high to tempt a high drive
   task automatic lamps_on;
      for (int i = 0; i < 3; i++) begin
         cfg[i] = '{1'b1, 1'b1, 1'b0, 1'b1};
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Mixed modes per pin, both data patterns
   task automatic t_gpio;
      int md;
      gled_vec_t d;
      gled_vec_t eo;
      gled_vec_t el;
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 2; k++) begin
            d = k ? 3'h2 : 3'h5;
            for (int i = 0; i < 3; i++) begin
               md = (m + i) % 3;
               cfg[i] = '{1'b0, md != 0, md == 2, d[i]};
               ext_en[i] = (md == 0);
               eo[i] = (md == 1) || (md == 2 && !d[i]);
               el[i] = (md == 0) ? ~d[i] : d[i];
            end
            ext_val = ~d;
            tick(4);
            chk(oe, eo, "gpio enable");
            chk(pin_lvl, el, "gpio level");
            chk(din, el, "gpio input");
         end
      end
      ext_en = 3'h0;
      $display("test gpio done");
   endtask

   // Static lamp states over the link table
   task automatic t_lamps;
      gled_link_s ls [5];
      gled_vec_t  ex [5];
      ls = '{5'h00, 5'h10, 5'h1A, 5'h1C, 5'h12};
      ex = '{3'h1, 3'h3, 3'h6, 3'h3, 3'h7};
      lamps_on();
      for (int j = 0; j < 5; j++) begin
         link = ls[j];
         tick(4);
         chk(oe, ex[j], "lamp enables");
         chk(out, 3'h0, "lamp drive");
      end
      $display("test lamps done");
   endtask

   // Off pulse, minimum on, back-to-back repeat
   task automatic t_activity;
      int n;
      lamps_on();
      link = 5'h12;
      tick(4);
      link.activity = 1'b1;
      wait_for(1'b0);
      run(1'b0, 40, n);
      chk_n(n, PULSE, "first off pulse");
      run(1'b1, 40, n);
      chk_n(n, PULSE, "on between pulses");
      link.activity = 1'b0;
      run(1'b0, 40, n);
      chk_n(n, PULSE, "repeat off pulse");
      run(1'b1, 40, n);
      chk_n(n, 40, "lit when quiet");
      $display("test activity done");
   endtask

   // Reset in mid-pulse, then link loss
   task automatic t_reset_abort;
      int n;
      link.activity = 1'b1;
      tick(1);
      link.activity = 1'b0;
      wait_for(1'b0);
      tick(2);
      srst = 1'b1;
      tick(2);
      chk(oe, 3'h0, "reset enable");
      chk(din, 3'h0, "reset input");
      srst = 1'b0;
      tick(3);
      chk(oe, 3'h7, "lamps after reset");
      run(1'b1, 20, n);
      chk_n(n, 20, "no leftover pulse");
      link.link_up = 1'b0;
      tick(3);
      chk(oe, 3'h1, "link lost");
      $display("test reset done");
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      srst = 1'b1;
      cfg = '0;
      link = '0;
      ext_en = 3'h0;
      ext_val = 3'h0;
      fails = 0;
      tests_run = 0;
      repeat (12) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      tick(2);
      t_gpio();
      t_lamps();
      t_activity();
      t_reset_abort();
      finish_test();
   end
endmodule // gled_indicator_port_bench
